// [hw/uhc_defines.svh]
// Offsets, field positions, reset values and timing counts of the control block
`ifndef UHC_DEFINES_SVH
`define UHC_DEFINES_SVH

`define UHC_CLK_MHZ        100
// Wishbone byte addresses
`define UHC_ADR_CMD        8'h00
`define UHC_ADR_ISR        8'h04
`define UHC_ADR_IMR        8'h08
`define UHC_ADR_STAT       8'h0C
// Command register fields
`define UHC_CMD_RUN_BIT    0
`define UHC_CMD_SUSP_BIT   3
`define UHC_CMD_FGR_BIT    4
`define UHC_CMD_DBG_BIT    5
// Interrupt status and mask fields
`define UHC_ISR_RES_BIT    0
`define UHC_ISR_STEP_BIT   1
`define UHC_ISR_EOP_BIT    2
`define UHC_ISR_W          3
// Live status fields
`define UHC_STAT_HALT_BIT  0
`define UHC_STAT_SUSP_BIT  1
`define UHC_STAT_DRV_BIT   2
`define UHC_STAT_EOP_BIT   3
// Reset values
`define UHC_IMR_RST        3'h0
// Low-speed end of packet: two bit times SE0, one bit time J
`define UHC_EOP_SE0_NS     1333
`define UHC_EOP_J_NS       667
`define UHC_EOP_SE0_CYC    ((`UHC_EOP_SE0_NS * `UHC_CLK_MHZ + 999) / 1000)
`define UHC_EOP_J_CYC      ((`UHC_EOP_J_NS * `UHC_CLK_MHZ + 999) / 1000)

`endif

// [hw/uhc_pkg.sv]
// Types shared by the suspend, resume and step-debug control logic
package uhc_pkg;

  // Schedule execution states
  typedef enum logic [2:0] {
    uhc_st_halted  = 3'b001,
    uhc_st_running = 3'b010,
    uhc_st_txn     = 3'b100
  } uhc_sched_state_type;

  // End-of-packet generator states
  typedef enum logic [2:0] {
    uhc_eop_idle = 3'b001,
    uhc_eop_se0  = 3'b010,
    uhc_eop_j    = 3'b100
  } uhc_eop_state_type;

  typedef struct packed {
    uhc_eop_state_type st;
    logic [7:0]        cnt;
    logic              done;
  } uhc_eop_regs_type;

  typedef struct packed {
    uhc_sched_state_type st;
    logic                run;
    logic                susp;
    logic                force_resume_signal;
    logic                dbg;
    logic [2:0]          isr;
    logic [2:0]          imr;
    logic                ack;
    logic [31:0]         rdata;
    logic                dp_s1;
    logic                dm_s1;
    logic                dp_s2;
    logic                dm_s2;
    logic                k_prev;
    logic                eop_start;
    logic                pin_dp;
    logic                pin_dm;
    logic                pin_oe_n;
  } uhc_ctl_regs_type;

endpackage : uhc_pkg

// [hw/uhc_eop_if.sv]
// Handshake between the control logic and the end-of-packet generator
`timescale 1ns/1ps
`default_nettype none
interface uhc_eop_if;
  logic start;
  logic busy;
  logic done;
  logic se0;
  logic j;
  modport gen (input start, output busy, output done, output se0, output j);
  modport ctl (output start, input busy, input done, input se0, input j);
endinterface : uhc_eop_if
`default_nettype wire

// [hw/uhc_eop_gen.sv]
// Low-speed end-of-packet generator: SE0 then J, then a done pulse
`timescale 1ns/1ps
`default_nettype none
`include "uhc_defines.svh"
module uhc_eop_gen (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  uhc_eop_if.gen    eop
);

  uhc_pkg::uhc_eop_regs_type r;
  uhc_pkg::uhc_eop_regs_type next_r;

  // Sequence timing; start is ignored while a sequence runs
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    unique case (r.st)
      uhc_pkg::uhc_eop_idle: begin
        if (eop.start) begin
          next_r.st  = uhc_pkg::uhc_eop_se0;
          next_r.cnt = 8'(`UHC_EOP_SE0_CYC - 1);
        end
      end
      uhc_pkg::uhc_eop_se0: begin
        if (r.cnt == 8'h00) begin
          next_r.st  = uhc_pkg::uhc_eop_j;
          next_r.cnt = 8'(`UHC_EOP_J_CYC - 1);
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      uhc_pkg::uhc_eop_j: begin
        if (r.cnt == 8'h00) begin
          next_r.st   = uhc_pkg::uhc_eop_idle;
          next_r.done = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      default: next_r.st = uhc_pkg::uhc_eop_idle;
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r.st   <= uhc_pkg::uhc_eop_idle;
      r.cnt  <= 8'h00;
      r.done <= 1'b0;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  // Outputs straight from state flops
  assign eop.busy = (r.st != uhc_pkg::uhc_eop_idle);
  assign eop.se0  = (r.st == uhc_pkg::uhc_eop_se0);
  assign eop.j    = (r.st == uhc_pkg::uhc_eop_j);
  assign eop.done = r.done;

endmodule : uhc_eop_gen
`default_nettype wire

// [hw/uhc_ctl.sv]
// Step-debug, global suspend and forced resume control with Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "uhc_defines.svh"

// What this block does
// - Step-debug on: run bit is cleared after every finished transaction.
// - In step-debug, next transaction waits until software sets run again.
// - While force-resume is one, resume K-state is driven on the bus.
// - In suspend, connect, disconnect or K-state sets force-resume by hardware.
// - Force-resume falling from one to zero sends a low-speed EOP.
// - Force-resume reads back one until that EOP has completed.
// - While suspend-request is one, no new transaction starts; one already running finishes.
// - In suspend, resume signalling is detected and can interrupt the system.
// - Clearing run lets the current transaction finish, then halts.
// - Halted flag rises once stopped after run was cleared.
module uhc_ctl (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Schedule engine handshake, same clock
  output logic             txn_allow_o,
  input  wire logic        txn_start_i,
  input  wire logic        txn_done_i,
  input  wire logic        port_conn_change_i,
  // Bus line state from the transceiver, asynchronous
  input  wire logic        line_dp_i,
  input  wire logic        line_dm_i,
  // Bus drive, enable active low
  output logic             usb_dp_o,
  output logic             usb_dm_o,
  output logic             usb_oe_n_o,
  // Status
  output logic             suspended_o,
  output logic             controller_halted_flag_o,
  output logic             irq_o
);

  uhc_pkg::uhc_ctl_regs_type r;
  uhc_pkg::uhc_ctl_regs_type next_r;

  uhc_eop_if eop ();

  logic       req;
  logic       wr_take;
  logic       rd_take;
  logic       wr_cmd;
  logic       wr_imr;
  logic       rd_isr;
  logic       line_k;
  logic       k_rise;
  logic       fgr_rb;
  logic       res_evt;
  logic       fgr_clear;
  logic       fgr_set_sw;
  logic       step_evt;
  logic [7:0] cmd_rb;
  logic [3:0] stat_rb;
  logic [31:0] rd_mux;
  logic [2:0] isr_set;

  // Bus decode; writes and read side effects land on the ack edge
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_take = req & wb_we_i & r.ack;
  assign rd_take = req & ~wb_we_i & r.ack;
  assign wr_cmd  = wr_take & wb_sel_i[0] & (wb_adr_i == `UHC_ADR_CMD);
  assign wr_imr  = wr_take & wb_sel_i[0] & (wb_adr_i == `UHC_ADR_IMR);
  assign rd_isr  = rd_take & (wb_adr_i == `UHC_ADR_ISR);

  // Line state seen only after the second synchroniser stage
  assign line_k = ~r.dp_s2 & r.dm_s2;
  assign k_rise = line_k & ~r.k_prev;

  // Readback holds one through the pending start and the EOP itself
  assign fgr_rb = r.force_resume_signal | r.eop_start | eop.busy;

  // Resume event only counts in suspend and while we are not signalling
  assign res_evt = r.susp & ~fgr_rb
                 & (port_conn_change_i | k_rise);

  // Software edges on force-resume; a hardware set wins over a clear
  assign fgr_clear  = wr_cmd & r.force_resume_signal & ~wb_dat_i[`UHC_CMD_FGR_BIT]
                    & ~res_evt;
  assign fgr_set_sw = wr_cmd & ~fgr_rb & wb_dat_i[`UHC_CMD_FGR_BIT];

  // End of a transaction under step-debug
  assign step_evt = (r.st == uhc_pkg::uhc_st_txn) & txn_done_i & r.dbg;

  // Sticky interrupt sources
  always_comb begin
    isr_set                   = 3'h0;
    isr_set[`UHC_ISR_RES_BIT]  = res_evt;
    isr_set[`UHC_ISR_STEP_BIT] = step_evt;
    isr_set[`UHC_ISR_EOP_BIT]  = eop.done;
  end

  // Register readback images
  always_comb begin
    cmd_rb                      = 8'h00;
    cmd_rb[`UHC_CMD_RUN_BIT]    = r.run;
    cmd_rb[`UHC_CMD_SUSP_BIT]   = r.susp;
    cmd_rb[`UHC_CMD_FGR_BIT]    = fgr_rb;
    cmd_rb[`UHC_CMD_DBG_BIT]    = r.dbg;
    stat_rb                     = 4'h0;
    stat_rb[`UHC_STAT_HALT_BIT] = (r.st == uhc_pkg::uhc_st_halted);
    stat_rb[`UHC_STAT_SUSP_BIT] = r.susp;
    stat_rb[`UHC_STAT_DRV_BIT]  = r.force_resume_signal;
    stat_rb[`UHC_STAT_EOP_BIT]  = eop.busy;
  end

  // Read data mux; unmapped addresses answer with zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `UHC_ADR_CMD:  rd_mux = {24'h00_0000, cmd_rb};
      `UHC_ADR_ISR:  rd_mux = {29'h0000_0000, r.isr};
      `UHC_ADR_IMR:  rd_mux = {29'h0000_0000, r.imr};
      `UHC_ADR_STAT: rd_mux = {28'h000_0000, stat_rb};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Next-state logic for all control state
  always_comb begin
    next_r = r;

    // Two-stage synchroniser on the line inputs
    next_r.dp_s1  = line_dp_i;
    next_r.dm_s1  = line_dm_i;
    next_r.dp_s2  = r.dp_s1;
    next_r.dm_s2  = r.dm_s1;
    next_r.k_prev = line_k;

    // Classic Wishbone: one wait state, ack for a single cycle
    next_r.ack = req & ~r.ack;
    if (req & ~r.ack) begin
      next_r.rdata = rd_mux;
    end

    // Schedule execution
    unique case (r.st)
      uhc_pkg::uhc_st_halted: begin
        if (r.run & ~r.susp & ~fgr_rb) begin
          next_r.st = uhc_pkg::uhc_st_running;
        end
      end
      uhc_pkg::uhc_st_running: begin
        if (~r.run | r.susp | fgr_rb) begin
          next_r.st = uhc_pkg::uhc_st_halted;
        end else if (txn_start_i) begin
          next_r.st = uhc_pkg::uhc_st_txn;
        end
      end
      uhc_pkg::uhc_st_txn: begin
        // Current transaction always runs to its end
        if (txn_done_i) begin
          if (r.dbg) begin
            next_r.run = 1'b0;
            next_r.st  = uhc_pkg::uhc_st_halted;
          end else if (r.run) begin
            next_r.st = uhc_pkg::uhc_st_running;
          end else begin
            next_r.st = uhc_pkg::uhc_st_halted;
          end
        end
      end
      default: next_r.st = uhc_pkg::uhc_st_halted;
    endcase

    // Software writes to the command bits
    if (wr_cmd) begin
      next_r.run  = wb_dat_i[`UHC_CMD_RUN_BIT];
      next_r.susp = wb_dat_i[`UHC_CMD_SUSP_BIT];
      next_r.dbg  = wb_dat_i[`UHC_CMD_DBG_BIT];
    end
    if (wr_imr) begin
      next_r.imr = wb_dat_i[2:0];
    end

    // Force-resume: hardware set, software set and clear
    next_r.eop_start = fgr_clear;
    if (fgr_clear) begin
      next_r.force_resume_signal = 1'b0;
    end
    if (fgr_set_sw | res_evt) begin
      next_r.force_resume_signal = 1'b1;
    end

    // Sticky status, cleared by a read; a new event wins
    next_r.isr = (r.isr & ~(rd_isr ? 3'h7 : 3'h0)) | isr_set;

    // Pin drive: resume K, then EOP SE0 and J, else released
    next_r.pin_oe_n = 1'b1;
    next_r.pin_dp   = 1'b0;
    next_r.pin_dm   = 1'b0;
    if (r.force_resume_signal) begin
      next_r.pin_oe_n = 1'b0;
      next_r.pin_dm   = 1'b1;
    end else if (eop.se0) begin
      next_r.pin_oe_n = 1'b0;
    end else if (eop.j) begin
      next_r.pin_oe_n = 1'b0;
      next_r.pin_dp   = 1'b1;
    end
  end

  // State register; constants only under reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r          <= '0;
      r.st       <= uhc_pkg::uhc_st_halted;
      r.imr      <= `UHC_IMR_RST;
      r.pin_oe_n <= 1'b1;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  // Low-speed EOP sequencer, reset with this block
  uhc_eop_gen u_eop (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .eop       (eop.gen)
  );
  assign eop.start = r.eop_start;

  // No new transaction while suspended, resuming or halting
  assign txn_allow_o = (r.st == uhc_pkg::uhc_st_running) & r.run
                     & ~r.susp & ~fgr_rb;

  // Outputs
  assign wb_ack_o                 = r.ack;
  assign wb_dat_o                 = r.rdata;
  assign usb_dp_o                 = r.pin_dp;
  assign usb_dm_o                 = r.pin_dm;
  assign usb_oe_n_o               = r.pin_oe_n;
  assign suspended_o              = r.susp;
  assign controller_halted_flag_o = (r.st == uhc_pkg::uhc_st_halted);
  assign irq_o                    = |(r.isr & r.imr);

endmodule : uhc_ctl
`default_nettype wire

// [tb/uhc_usb_dev.sv]
// Model of the devices on the root port: idle J, remote wakeup K
`timescale 1ns/1ps
`default_nettype none
module uhc_usb_dev (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic send_k_i,
  input  wire logic usb_dp_i,
  input  wire logic usb_dm_i,
  input  wire logic usb_oe_n_i,
  output logic      line_dp_o,
  output logic      line_dm_o
);
  logic [5:0] k_cnt;
  // Wakeup K lasts 30 cycles so the host sampler cannot miss it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      k_cnt <= 6'h00;
    end else if (send_k_i) begin
      k_cnt <= 6'h1E;
    end else if (k_cnt != 6'h00) begin
      k_cnt <= k_cnt - 6'h01;
    end
  end
  // Host drive wins; a released line sits at J through the pull-up
  assign line_dp_o = !usb_oe_n_i ? usb_dp_i : (k_cnt == 6'h00);
  assign line_dm_o = !usb_oe_n_i ? usb_dm_i : (k_cnt != 6'h00);
endmodule : uhc_usb_dev
`default_nettype wire

// [tb/uhc_ctl_chk.sv]
// Assertion checker for the suspend, resume and step-debug control
`timescale 1ns/1ps
`default_nettype none
`include "uhc_defines.svh"
module uhc_ctl_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic txn_allow_o,
  input wire logic txn_start_i,
  input wire logic txn_done_i,
  input wire logic port_conn_change_i,
  input wire logic usb_dp_o,
  input wire logic usb_dm_o,
  input wire logic usb_oe_n_o,
  input wire logic suspended_o,
  input wire logic controller_halted_flag_o,
  input wire logic irq_o
);
  localparam int se0_cyc = `UHC_EOP_SE0_CYC;
  localparam int j_cyc = `UHC_EOP_J_CYC;
  wire logic kst = !usb_oe_n_o && !usb_dp_o && usb_dm_o;
  wire logic se0 = !usb_oe_n_o && !usb_dp_o && !usb_dm_o;
  wire logic jst = !usb_oe_n_o && usb_dp_o && !usb_dm_o;
  logic [8:0] se0_cnt;
  logic [8:0] j_cnt;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Run lengths of both halves of the end of packet
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      se0_cnt <= 9'h000;
      j_cnt <= 9'h000;
    end else begin
      se0_cnt <= se0 ? se0_cnt + 9'h001 : 9'h000;
      j_cnt <= jst ? j_cnt + 9'h001 : 9'h000;
    end
  end
  property p_rst;
    $rose(rst_n_i) |-> usb_oe_n_o && !suspended_o && !irq_o
      && controller_halted_flag_o && !txn_allow_o;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_susp; suspended_o |-> !txn_allow_o; endproperty
  a_susp: assert property (p_susp) else $error("transfer in suspend");
  property p_wake;
    (suspended_o && usb_oe_n_o)[*4] ##0 port_conn_change_i |-> ##[1:3] kst;
  endproperty
  a_wake: assert property (p_wake) else $error("no resume drive");
  property p_k_end; $fell(kst) |-> ##[0:2] se0; endproperty
  a_k_end: assert property (p_k_end) else $error("resume end no EOP");
  property p_se0; $fell(se0) |-> jst && se0_cnt == se0_cyc; endproperty
  a_se0: assert property (p_se0) else $error("SE0 length wrong");
  property p_j; $fell(jst) |-> usb_oe_n_o && j_cnt == j_cyc; endproperty
  a_j: assert property (p_j) else $error("J length wrong");
  property p_hold; controller_halted_flag_o |-> !txn_allow_o; endproperty
  a_hold: assert property (p_hold) else $error("start while halted");
  property p_finish;
    txn_allow_o && txn_start_i ##1 !txn_done_i
      |-> !controller_halted_flag_o && !txn_allow_o;
  endproperty
  a_finish: assert property (p_finish) else $error("cut short");
  property p_halt;
    $rose(controller_halted_flag_o) |-> $past(txn_done_i) || $past(txn_allow_o);
  endproperty
  a_halt: assert property (p_halt) else $error("halted too early");
endmodule : uhc_ctl_chk
bind uhc_ctl uhc_ctl_chk u_chk (.ref_clk_i, .rst_n_i, .txn_allow_o,
  .txn_start_i, .txn_done_i, .port_conn_change_i, .usb_dp_o, .usb_dm_o,
  .usb_oe_n_o, .suspended_o, .controller_halted_flag_o, .irq_o);
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the suspend, resume and step-debug control
`timescale 1ns/1ps
`default_nettype none
`include "uhc_defines.svh"
module tb_top;
  logic ref_clk_i, rst_n_i, clk_en_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic txn_allow_o, txn_start_i, txn_done_i, port_conn_change_i, send_k;
  logic line_dp_i, line_dm_i, usb_dp_o, usb_dm_o, usb_oe_n_o, suspended_o;
  logic controller_halted_flag_o, irq_o;
  int failures, comparisons, cycles;
  uhc_ctl DUT (.ref_clk_i, .rst_n_i, .clk_en_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .txn_allow_o, .txn_start_i, .txn_done_i, .port_conn_change_i,
    .line_dp_i, .line_dm_i, .usb_dp_o, .usb_dm_o, .usb_oe_n_o,
    .suspended_o, .controller_halted_flag_o, .irq_o);
  uhc_usb_dev u_dev (.ref_clk_i, .rst_n_i, .send_k_i(send_k),
    .usb_dp_i(usb_dp_o), .usb_dm_i(usb_dm_o), .usb_oe_n_i(usb_oe_n_o),
    .line_dp_o(line_dp_i), .line_dm_o(line_dm_i));
  task automatic close_out;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask : chk
  // Classic single cycle; waits for ack, read data taken at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  // One-cycle strobe: 0 start, 1 done, 2 connect change, 3 wakeup K
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    txn_start_i <= (k == 0);
    txn_done_i <= (k == 1);
    port_conn_change_i <= (k == 2);
    send_k <= (k == 3);
    @(posedge ref_clk_i);
    {txn_start_i, txn_done_i, port_conn_change_i, send_k} <= 4'h0;
  endtask : pulse
  task automatic t_reset;
    wb(1'h0, `UHC_ADR_CMD, 32'h0);
    chk(q, 32'h0, "command not clear");
    wb(1'h0, `UHC_ADR_STAT, 32'h0);
    chk(q, 32'h1, "status not halted only");
    wb(1'h1, 8'h10, 32'hFFFFFFFF);
    wb(1'h0, 8'h10, 32'h0);
    chk(q, 32'h0, "unmapped read not zero");
    $display("t_reset finished");
  endtask : t_reset
  task automatic t_run;
    wb(1'h1, `UHC_ADR_CMD, 32'h01);
    repeat (20) if (txn_allow_o !== 1'h1) @(posedge ref_clk_i);
    pulse(0);
    wb(1'h1, `UHC_ADR_CMD, 32'h00);
    chk({controller_halted_flag_o, txn_allow_o}, 2'h0, "cut short");
    pulse(1);
    @(posedge ref_clk_i);
    chk(controller_halted_flag_o, 1'h1, "not halted");
    $display("t_run finished");
  endtask : t_run
  task automatic t_step;
    wb(1'h1, `UHC_ADR_IMR, 32'h0);
    wb(1'h1, `UHC_ADR_CMD, 32'h21);
    repeat (20) if (txn_allow_o !== 1'h1) @(posedge ref_clk_i);
    pulse(0);
    pulse(1);
    wb(1'h0, `UHC_ADR_CMD, 32'h0);
    chk(q, 32'h20, "run not cleared by step");
    chk(txn_allow_o, 1'h0, "next transfer allowed");
    chk(irq_o, 1'h0, "masked event raised irq");
    wb(1'h1, `UHC_ADR_IMR, 32'h2);
    repeat (2) @(posedge ref_clk_i);
    chk(irq_o, 1'h1, "unmasked event silent");
    wb(1'h0, `UHC_ADR_ISR, 32'h0);
    chk(q, 32'h2, "step status wrong");
    repeat (2) @(posedge ref_clk_i);
    chk(irq_o, 1'h0, "read did not clear");
    wb(1'h1, `UHC_ADR_CMD, 32'h00);
    $display("t_step finished");
  endtask : t_step
  task automatic t_susp;
    wb(1'h1, `UHC_ADR_IMR, 32'h5);
    wb(1'h1, `UHC_ADR_CMD, 32'h08);
    repeat (4) @(posedge ref_clk_i);
    chk({suspended_o, txn_allow_o}, 2'h2, "not suspended");
    pulse(3);
    repeat (8) @(posedge ref_clk_i);
    wb(1'h0, `UHC_ADR_CMD, 32'h0);
    chk(q, 32'h18, "wakeup did not set resume");
    chk({usb_oe_n_o, usb_dp_o, usb_dm_o}, 3'h1, "no K driven");
    chk(irq_o, 1'h1, "no wakeup interrupt");
    // Resume held far shorter than real time; no hardware timer
    repeat (500) @(posedge ref_clk_i);
    wb(1'h1, `UHC_ADR_CMD, 32'h00);
    wb(1'h0, `UHC_ADR_CMD, 32'h0);
    chk(q, 32'h10, "resume bit fell early");
    wb(1'h0, `UHC_ADR_STAT, 32'h0);
    chk(q[3], 1'h1, "no end of packet");
    repeat (250) @(posedge ref_clk_i);
    wb(1'h0, `UHC_ADR_CMD, 32'h0);
    chk(q, 32'h0, "resume bit stuck");
    wb(1'h1, `UHC_ADR_CMD, 32'h08);
    repeat (6) @(posedge ref_clk_i);
    pulse(2);
    repeat (6) @(posedge ref_clk_i);
    wb(1'h0, `UHC_ADR_CMD, 32'h0);
    chk(q, 32'h18, "connect did not resume");
    wb(1'h1, `UHC_ADR_CMD, 32'h08);
    repeat (250) @(posedge ref_clk_i);
    wb(1'h1, `UHC_ADR_CMD, 32'h00);
    wb(1'h0, `UHC_ADR_ISR, 32'h0);
    chk(q, 32'h5, "resume events missing");
    repeat (2) @(posedge ref_clk_i);
    chk({usb_oe_n_o, irq_o}, 2'h2, "not idle after resume");
    $display("t_susp finished");
  endtask : t_susp
  // Byte lane refusal, then a reset in suspend while resume is driven
  task automatic t_misc;
    wb_sel_i <= 4'hE;
    wb(1'h1, `UHC_ADR_IMR, 32'h7);
    wb_sel_i <= 4'hF;
    wb(1'h0, `UHC_ADR_IMR, 32'h0);
    chk(q, 32'h5, "write without lane 0 landed");
    wb(1'h1, `UHC_ADR_CMD, 32'h08);
    pulse(2);
    repeat (4) @(posedge ref_clk_i);
    chk({usb_oe_n_o, irq_o}, 2'h1, "no resume before reset");
    rst_n_i <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
    chk({suspended_o, usb_oe_n_o, irq_o}, 3'h2, "reset left state");
    rst_n_i <= 1'h1;
    wb(1'h0, `UHC_ADR_CMD, 32'h0);
    chk(q, 32'h0, "command survived reset");
    wb(1'h0, `UHC_ADR_IMR, 32'h0);
    chk(q, 32'h0, "mask survived reset");
    $display("t_misc finished");
  endtask : t_misc
  // Free-running clock and hang watchdog
  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("ERROR %0t: watchdog expired", $time);
      close_out();
    end
  end
  initial begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, send_k} = 5'h0;
    {txn_start_i, txn_done_i, port_conn_change_i} = 3'h0;
    {wb_adr_i, wb_dat_i} = 40'h0;
    clk_en_i = 1'h1;
    wb_sel_i = 4'hF;
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    t_reset();
    t_run();
    t_step();
    t_susp();
    t_misc();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
